// ===== hdl/edge_rate_meter.v
// Two-stage synchroniser plus rising-edge counter for one pin.
// Assumes the pin is asynchronous to CLK; count is latched by sample_in.
`timescale 1ns/1ns
module edge_rate_meter #(
  parameter W = 12
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire pin_in,
  input wire sample_in,
  output reg [W-1:0] rate_out,
  output wire level_out,
  output reg [W-1:0] high_out
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg [W-1:0] cnt_q;
  reg [W-1:0] hcnt_q;
  wire rise = s2_q & ~s3_q;

  assign level_out = s2_q;

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      cnt_q <= {W{1'b0}};
      hcnt_q <= {W{1'b0}};
      rate_out <= {W{1'b0}};
      high_out <= {W{1'b0}};
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (sample_in) begin
        rate_out <= cnt_q;
        high_out <= hcnt_q;
        cnt_q <= {W{1'b0}};
        hcnt_q <= {W{1'b0}};
      end else begin
        // Saturate rather than wrap
        if (rise && cnt_q != {W{1'b1}})
          cnt_q <= cnt_q + 1'b1;
        if (s2_q && hcnt_q != {W{1'b1}})
          hcnt_q <= hcnt_q + 1'b1;
      end
    end
  end
endmodule // edge_rate_meter

// ===== hdl/motor_loop_regs.vh
// Constants for the closed-loop motor core: register offsets, fields,
// reset values and timing counts. Assumes a 50 MHz system clock.
`ifndef MOTOR_LOOP_REGS_VH
`define MOTOR_LOOP_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, word aligned)
// ----------------------------------------------------------------------
`define ADDR_CTRL      8'h00
`define ADDR_PERIOD    8'h04
`define ADDR_GAIN_P    8'h08
`define ADDR_GAIN_I    8'h0c
`define ADDR_GAIN_D    8'h10
`define ADDR_LIMITS    8'h14
`define ADDR_MEAS      8'h18
`define ADDR_DUTY      8'h1c
`define ADDR_STATUS    8'h20
`define ADDR_ERRORS    8'h24

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTRL_MOTOR_ON   0
`define CTRL_FB_EN      1
`define CTRL_PROBE_FB   2
`define CTRL_PROBE_IN   3
`define CTRL_SLEEP      4
`define CTRL_FB_FREQ    5
`define CTRL_IN_PULSE   6
`define CTRL_RESET      32'h0000_0000

// ----------------------------------------------------------------------
// Reset values and numeric limits
// ----------------------------------------------------------------------
`define PERIOD_RESET    8'h01
`define LIMITS_RESET    32'h0000_0258
`define DUTY_MAX        600
`define SETTLE_BAND     20
`define SPEED_OFFSET    2048
`define INTEG_MAX       32'sh000f_ffff

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_HZ          50000000
`define MS_NS           1000000
`define CLK_NS          20
`define MS_CYCLES       (`MS_NS / `CLK_NS)
`define PROBE_NS        150000
`define PROBE_CYCLES    (`PROBE_NS / `CLK_NS)
`define SLOW_BLINK_HZ   1
`define FAST_BLINK_HZ   16
`define SLOW_HALF       (`CLK_HZ / (2 * `SLOW_BLINK_HZ))
`define FAST_HALF       (`CLK_HZ / (2 * `FAST_BLINK_HZ))
`define PWM_STEPS       600

`endif

// ===== hdl/pid_motor_loop.v
// Closed-loop single-motor PID core with PWM, fault and status outputs.
// Assumes ADC samples arrive as sync words on the CLK domain; pins sync'd.
//
// Contract
// R1: Error LED lights when any error other than held-off stops the motor.
// R2: Fault pin driven high on error, otherwise released, never driven low.
// R3: Status LED off while a non-held-off error stops the motor.
// R4: Status LED blinks once per second if held off or speed duty zero.
// R5: Status LED steady when on and settled (within 20, or duty at target).
// R6: Status LED blinks sixteen times per second when on but unsettled.
// R7: Aux pin high while powered, released only during sleep.
// R8: Probe enabled: aux driven low about 150 us each PID period.
// R9: Transmit line sends non-inverted serial bytes from replies or host.
// R10: Control input used per mode: serial, analog sample, or pulse width. No serial mode here: CTRL_IN_PULSE picks pulse width, else the ADC sample.
// R11: Feedback is analog voltage or rate of rising edges in frequency mode.
// R12: Active-low reset input resets the controller; pulled high externally.
// R13: Computation stages run once per PID period, set in 1 ms steps.
// R14: Input measured 0..4095, scaled into a 0..4095 target. Pulse mode divides the 12-bit ctl_high by 33, reaching only 0..124.
// R15: Feedback measured 0..4095, scaled feedback min 0 max 4095.
// R16: Motor current measured as unsigned 0..255.
// R17: Error equals scaled feedback minus target each period.
// R18: Duty target is P+I+D sum, bounded to -600..+600.
// R19: Duty target reduced by acceleration, current and max-duty limits.
// R20: Duty signed: +600 full forward, -600 full reverse, 0 off.
// R21: Feedback disabled: duty target equals target minus 2048, limits kept.
// R22: Commanded off stops driving yet keeps measuring and computing.
// R23: Integral and intermediate PID arithmetic saturate, never flip sign.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "motor_loop_regs.vh"
module pid_motor_loop #(
  parameter MS_CYCLES = `MS_CYCLES,
  parameter SLOW_HALF = `SLOW_HALF,
  parameter FAST_HALF = `FAST_HALF
) (
  input wire CLK_IN,
  input wire ARST_N_IN,
  input wire [7:0] ADDR_IN,
  input wire [31:0] WDATA_IN,
  input wire WR_IN,
  input wire RD_IN,
  output reg [31:0] RDATA_OUT,
  input wire [11:0] INPUT_ADC_IN,
  input wire [11:0] FEEDBACK_ADC_IN,
  input wire [7:0] CURRENT_ADC_IN,
  input wire CONTROL_IN,
  input wire feedback_in,
  input wire SERIAL_TX_DATA_IN,
  output reg SERIAL_TX_OUT,
  output reg [15:0] ERROR_FLAGS_OUT,
  output reg PWM_OUT,
  output reg DIR_OUT,
  output reg FAULT_OUT,
  output reg FAULT_OE_OUT,
  output reg AUX_OUT,
  output reg AUX_OE_OUT,
  output reg ERR_LED_OUT,
  output reg STATUS_LED_OUT
);
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function signed [31:0] clamp;
    input signed [47:0] v;
    input signed [31:0] lim;
    begin
      if (v > lim)
        clamp = lim;
      else if (v < -lim)
        clamp = -lim;
      else
        clamp = v[31:0];
    end
  endfunction

  function [11:0] sat12;
    input signed [31:0] v;
    begin
      if (v < 0)
        sat12 = 12'h000;
      else if (v > 32'sd4095)
        sat12 = 12'hfff;
      else
        sat12 = v[11:0];
    end
  endfunction

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg [31:0] ctrl_q;
  reg [7:0] period_q;
  reg signed [15:0] kp_q;
  reg signed [15:0] ki_q;
  reg signed [15:0] kd_q;
  reg [31:0] limits_q;
  reg [15:0] errors_q;
  wire [9:0] max_duty = limits_q[9:0];
  wire [9:0] max_accel = limits_q[19:10];
  wire [7:0] max_current = limits_q[27:20];

  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin // R12
      ctrl_q <= `CTRL_RESET;
      period_q <= `PERIOD_RESET;
      kp_q <= 16'sh0000;
      ki_q <= 16'sh0000;
      kd_q <= 16'sh0000;
      limits_q <= `LIMITS_RESET;
      errors_q <= 16'h0000;
    end else if (WR_IN) begin
      case (ADDR_IN)
        `ADDR_CTRL: ctrl_q <= WDATA_IN;
        `ADDR_PERIOD: period_q <= (WDATA_IN[7:0] == 8'h00) ?
                                  8'h01 : WDATA_IN[7:0];
        `ADDR_GAIN_P: kp_q <= WDATA_IN[15:0];
        `ADDR_GAIN_I: ki_q <= WDATA_IN[15:0];
        `ADDR_GAIN_D: kd_q <= WDATA_IN[15:0];
        `ADDR_LIMITS: limits_q <= WDATA_IN;
        `ADDR_ERRORS: errors_q <= WDATA_IN[15:0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Pin sync and PID period timer
  // --------------------------------------------------------------------
  reg ctl1_q;
  reg ctl2_q;
  reg [31:0] ms_cnt_q;
  reg [7:0] per_cnt_q;
  reg tick_q;
  wire [11:0] fb_rate;
  wire [11:0] ctl_high;
  wire fb_level;

  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ctl1_q <= 1'b0;
      ctl2_q <= 1'b0;
      ms_cnt_q <= 32'h0000_0000;
      per_cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      ctl1_q <= CONTROL_IN;
      ctl2_q <= ctl1_q;
      tick_q <= 1'b0;
      if (ms_cnt_q == MS_CYCLES - 1) begin // R13
        ms_cnt_q <= 32'h0000_0000;
        if (per_cnt_q + 8'h01 >= period_q) begin
          per_cnt_q <= 8'h00;
          tick_q <= 1'b1;
        end else begin
          per_cnt_q <= per_cnt_q + 8'h01;
        end
      end else begin
        ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
      end
    end
  end

  // Pulse width counted in 20 ns clocks; /33 approximates 2/3 us units
  edge_rate_meter #(.W(12)) u_fb (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .pin_in(feedback_in),
    .sample_in(tick_q),
    .rate_out(fb_rate),
    .level_out(fb_level),
    .high_out()
  );

  edge_rate_meter #(.W(12)) u_ctl (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .pin_in(CONTROL_IN),
    .sample_in(tick_q),
    .rate_out(),
    .level_out(),
    .high_out(ctl_high)
  );

  // --------------------------------------------------------------------
  // Measurement and PID pipeline, one pass per period
  // --------------------------------------------------------------------
  reg [11:0] input_q;
  reg [11:0] feedback_q;
  reg [7:0] current_q;
  reg signed [31:0] error_q;
  reg signed [31:0] prev_err_q;
  reg signed [31:0] integ_q;
  reg signed [31:0] duty_tgt_q;
  reg signed [31:0] duty_q;
  reg [2:0] stage_q;
  localparam ST_IDLE = 3'd0;
  localparam ST_ERR = 3'd1;
  localparam ST_PID = 3'd2;
  localparam ST_LIM = 3'd3;

  wire signed [31:0] target_s = {20'h00000, input_q};
  wire signed [31:0] fb_s = {20'h00000, feedback_q};
  wire signed [47:0] p_term = kp_q * error_q;
  wire signed [47:0] i_term = ki_q * integ_q;
  wire signed [47:0] d_term = kd_q * (error_q - prev_err_q);
  wire signed [47:0] pid_sum = p_term + i_term + d_term;
  wire signed [47:0] integ_next = integ_q + error_q;
  wire signed [31:0] dmax = {22'h000000, max_duty};
  wire signed [31:0] dacc = {22'h000000, max_accel};
  wire over_current = max_current != 8'h00 && current_q > max_current;
  wire signed [31:0] accel_lim = (duty_tgt_q > duty_q + dacc) ?
    duty_q + dacc : (duty_tgt_q < duty_q - dacc) ? duty_q - dacc :
    duty_tgt_q;

  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      input_q <= 12'h000;
      feedback_q <= 12'h000;
      current_q <= 8'h00;
      error_q <= 32'sh0;
      prev_err_q <= 32'sh0;
      integ_q <= 32'sh0;
      duty_tgt_q <= 32'sh0;
      duty_q <= 32'sh0;
      stage_q <= ST_IDLE;
    end else begin
      case (stage_q)
        ST_IDLE: if (tick_q) begin
          // R10 R14
          input_q <= ctrl_q[`CTRL_IN_PULSE] ?
                     sat12({20'h00000, ctl_high} / 32'sd33) : INPUT_ADC_IN;
          // R11 R15
          feedback_q <= ctrl_q[`CTRL_FB_FREQ] ? fb_rate : FEEDBACK_ADC_IN;
          current_q <= CURRENT_ADC_IN; // R16
          stage_q <= ST_ERR;
        end
        ST_ERR: begin
          prev_err_q <= error_q;
          error_q <= fb_s - target_s; // R17
          stage_q <= ST_PID;
        end
        ST_PID: begin
          if (ctrl_q[`CTRL_FB_EN]) begin
            integ_q <= clamp(integ_next, `INTEG_MAX); // R23
            duty_tgt_q <= clamp(pid_sum, `DUTY_MAX); // R18 R23
          end else begin
            duty_tgt_q <= target_s - `SPEED_OFFSET; // R21
          end
          stage_q <= ST_LIM;
        end
        ST_LIM: begin
          // R19 R22: limits always applied; off only gates the bridge
          if (over_current)
            duty_q <= duty_q / 2;
          else
            duty_q <= clamp({{16{accel_lim[31]}}, accel_lim}, dmax);
          stage_q <= ST_IDLE;
        end
        default: stage_q <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // PWM, status and aux
  // --------------------------------------------------------------------
  reg [9:0] pwm_cnt_q;
  reg [31:0] slow_q;
  reg [31:0] fast_q;
  reg slow_led_q;
  reg fast_led_q;
  reg [31:0] probe_q;
  wire held_off = ~ctrl_q[`CTRL_MOTOR_ON];
  wire stop_err = |errors_q;
  wire [31:0] duty_mag = duty_q[31] ? -duty_q : duty_q;
  wire signed [31:0] diff = target_s - fb_s;
  wire settled = ctrl_q[`CTRL_FB_EN] ?
    (diff <= `SETTLE_BAND && diff >= -`SETTLE_BAND) :
    (duty_q == duty_tgt_q);
  wire probe_en = ctrl_q[`CTRL_PROBE_FB] | ctrl_q[`CTRL_PROBE_IN];

  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pwm_cnt_q <= 10'h000;
      slow_q <= 32'h0;
      fast_q <= 32'h0;
      slow_led_q <= 1'b0;
      fast_led_q <= 1'b0;
      probe_q <= 32'h0;
      PWM_OUT <= 1'b0;
      DIR_OUT <= 1'b0;
      FAULT_OUT <= 1'b0;
      FAULT_OE_OUT <= 1'b0;
      AUX_OUT <= 1'b0;
      AUX_OE_OUT <= 1'b0;
      ERR_LED_OUT <= 1'b0;
      STATUS_LED_OUT <= 1'b0;
      SERIAL_TX_OUT <= 1'b1;
      ERROR_FLAGS_OUT <= 16'h0000;
    end else begin
      pwm_cnt_q <= (pwm_cnt_q == `PWM_STEPS - 1) ? 10'h000 :
                   pwm_cnt_q + 10'h001;
      // R20 R22
      PWM_OUT <= ~held_off & ~stop_err & ({22'h0, pwm_cnt_q} < duty_mag);
      DIR_OUT <= duty_q[31];
      slow_q <= (slow_q == SLOW_HALF - 1) ? 32'h0 : slow_q + 32'h1;
      fast_q <= (fast_q == FAST_HALF - 1) ? 32'h0 : fast_q + 32'h1;
      if (slow_q == SLOW_HALF - 1)
        slow_led_q <= ~slow_led_q;
      if (fast_q == FAST_HALF - 1)
        fast_led_q <= ~fast_led_q;
      ERR_LED_OUT <= stop_err; // R1
      // Open-drain style so several fault lines may be tied
      FAULT_OUT <= 1'b1; // R2
      FAULT_OE_OUT <= stop_err; // R2
      if (stop_err)
        STATUS_LED_OUT <= 1'b0; // R3
      else if (held_off || (!ctrl_q[`CTRL_FB_EN] && duty_q == 0))
        STATUS_LED_OUT <= slow_led_q; // R4
      else if (settled)
        STATUS_LED_OUT <= 1'b1; // R5
      else
        STATUS_LED_OUT <= fast_led_q; // R6
      if (tick_q && probe_en)
        probe_q <= `PROBE_CYCLES; // R8
      else if (probe_q != 32'h0)
        probe_q <= probe_q - 32'h1;
      AUX_OUT <= (probe_q == 32'h0); // R8
      // Sleep releases the pin even mid-probe; the rest of the controller keeps running
      AUX_OE_OUT <= ~ctrl_q[`CTRL_SLEEP]; // R7
      SERIAL_TX_OUT <= SERIAL_TX_DATA_IN; // R9
      ERROR_FLAGS_OUT <= errors_q;
    end
  end

  // --------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------
  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      RDATA_OUT <= 32'h0;
    end else if (RD_IN) begin
      case (ADDR_IN)
        `ADDR_CTRL: RDATA_OUT <= ctrl_q;
        `ADDR_PERIOD: RDATA_OUT <= {24'h0, period_q};
        `ADDR_GAIN_P: RDATA_OUT <= {16'h0, kp_q};
        `ADDR_GAIN_I: RDATA_OUT <= {16'h0, ki_q};
        `ADDR_GAIN_D: RDATA_OUT <= {16'h0, kd_q};
        `ADDR_LIMITS: RDATA_OUT <= limits_q;
        `ADDR_MEAS: RDATA_OUT <= {current_q, feedback_q, input_q};
        `ADDR_DUTY: RDATA_OUT <= {duty_tgt_q[15:0], duty_q[15:0]};
        `ADDR_STATUS: RDATA_OUT <= {29'h0, settled, fb_level, ctl2_q};
        `ADDR_ERRORS: RDATA_OUT <= {16'h0, errors_q};
        default: RDATA_OUT <= 32'h0;
      endcase
    end else begin
      RDATA_OUT <= 32'h0;
    end
  end
endmodule // pid_motor_loop

// ===== testbench/motor_side_model.sv
// Far side of the core: sensor words, control pulses, tach edges, load.
// Assumes the bench sets sensor levels; everything moves on clk_in.
`timescale 1ns/1ns
module motor_side_model (
  input wire clk_in,
  input wire [11:0] fb_level_in,
  input wire [11:0] cmd_level_in,
  input wire pwm_in,
  output logic [11:0] input_adc_out = 12'h000,
  output logic [11:0] feedback_adc_out = 12'h000,
  output logic [7:0] current_adc_out = 8'h00,
  output logic control_out = 1'b0,
  output logic feedback_pin_out = 1'b0
);
  int tick = 0;
  always @(posedge clk_in) begin
    tick <= (tick == 499) ? 0 : tick + 1;
    input_adc_out <= cmd_level_in;
    feedback_adc_out <= fb_level_in;
    current_adc_out <= pwm_in ? 8'hff : 8'h00;
    control_out <= (tick < 75);
    feedback_pin_out <= tick[2];
  end
endmodule // motor_side_model

// ===== testbench/pid_motor_loop_properties.sv
// Checker for the motor core: fault, aux, status, bus and serial relations.
// Assumes it is bound to pid_motor_loop and sees only that module's ports.
`timescale 1ns/1ns
`include "motor_loop_regs.vh"
module pid_motor_loop_checker #(
  parameter MS_CYCLES = 100,
  parameter SLOW_HALF = 40,
  parameter FAST_HALF = 8
) (
  input wire CLK_IN,
  input wire ARST_N_IN,
  input wire [7:0] ADDR_IN,
  input wire [31:0] WDATA_IN,
  input wire WR_IN,
  input wire RD_IN,
  input wire [31:0] RDATA_OUT,
  input wire SERIAL_TX_DATA_IN,
  input wire SERIAL_TX_OUT,
  input wire [15:0] ERROR_FLAGS_OUT,
  input wire PWM_OUT,
  input wire FAULT_OUT,
  input wire FAULT_OE_OUT,
  input wire AUX_OUT,
  input wire AUX_OE_OUT,
  input wire ERR_LED_OUT,
  input wire STATUS_LED_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // ---------------------------------------------------------------------
  // Shadow of control bits, aux low-time counter
  // ---------------------------------------------------------------------
  logic sleep_q, off_q, probe_q;
  int low_q;
  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sleep_q <= 1'b0;
      off_q <= 1'b1;
      probe_q <= 1'b0;
      low_q <= 0;
    end else begin
      if (WR_IN && ADDR_IN == `ADDR_CTRL) begin
        sleep_q <= WDATA_IN[`CTRL_SLEEP];
        off_q <= !WDATA_IN[`CTRL_MOTOR_ON];
        probe_q <= WDATA_IN[`CTRL_PROBE_FB] | WDATA_IN[`CTRL_PROBE_IN];
      end
      low_q <= (AUX_OE_OUT && !AUX_OUT) ? low_q + 1 : 0;
    end
  end
  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  a_fault_never_low: assert property (
    FAULT_OE_OUT |-> FAULT_OUT) else $error("fault pin driven low");
  a_fault_on_error: assert property (
    (ERROR_FLAGS_OUT != 16'h0000) [*3] |-> FAULT_OE_OUT && ERR_LED_OUT)
    else $error("error not shown");
  a_quiet_no_error: assert property (
    (ERROR_FLAGS_OUT == 16'h0000) [*3] |-> !FAULT_OE_OUT && !ERR_LED_OUT)
    else $error("error shown without cause");
  a_status_dark: assert property (
    (ERROR_FLAGS_OUT != 16'h0000) [*3] |-> !STATUS_LED_OUT)
    else $error("status lit during error");
  a_aux_awake: assert property (
    !sleep_q [*3] |-> AUX_OE_OUT) else $error("aux released while awake");
  a_aux_asleep: assert property (
    sleep_q [*3] |-> !AUX_OE_OUT) else $error("aux driven while asleep");
  a_probe_start: assert property (
    $fell(AUX_OUT) && AUX_OE_OUT |-> probe_q)
    else $error("aux low without probe");
  a_probe_length: assert property (
    low_q <= `PROBE_CYCLES) else $error("aux low too long");
  a_read_idle: assert property (
    !RD_IN |=> RDATA_OUT == 32'h0000_0000) else $error("stray read data");
  a_motor_held: assert property (
    off_q [*3] |-> !PWM_OUT) else $error("pwm while off");
  a_tx_copy: assert property (
    $stable(SERIAL_TX_DATA_IN) [*3] |-> SERIAL_TX_OUT == SERIAL_TX_DATA_IN)
    else $error("tx not passed through");
  c_fault: cover property (FAULT_OE_OUT);
  c_probe: cover property ($fell(AUX_OUT) && AUX_OE_OUT);
  c_pwm: cover property ($rose(PWM_OUT));
endmodule // pid_motor_loop_checker

bind pid_motor_loop pid_motor_loop_checker #(
  .MS_CYCLES(MS_CYCLES), .SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)
) i_pid_motor_loop_checker (
  .CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .ADDR_IN(ADDR_IN),
  .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
  .SERIAL_TX_DATA_IN(SERIAL_TX_DATA_IN), .SERIAL_TX_OUT(SERIAL_TX_OUT),
  .ERROR_FLAGS_OUT(ERROR_FLAGS_OUT), .PWM_OUT(PWM_OUT),
  .FAULT_OUT(FAULT_OUT), .FAULT_OE_OUT(FAULT_OE_OUT), .AUX_OUT(AUX_OUT),
  .AUX_OE_OUT(AUX_OE_OUT), .ERR_LED_OUT(ERR_LED_OUT),
  .STATUS_LED_OUT(STATUS_LED_OUT)
);

// ===== testbench/pid_motor_loop_tb.sv
// Self-checking bench for the motor core: bus tasks and output checks.
// Assumes the design files and the far-side model are compiled first.
`timescale 1ns/1ns
`include "motor_loop_regs.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("Error at %0t: got %0h want %0h", $time, (a), (b)); end end
module pid_motor_loop_tb;
  localparam int MS = 100;
  localparam int SLOW = 40;
  localparam int FAST = 8;
  logic clk = 0, arst_n = 0, wr = 0, rd = 0, tx_bit = 1;
  logic [7:0] addr = 8'h00, cur_adc;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [11:0] in_adc, fb_adc, fb_level = 12'h000, cmd_level = 12'h800;
  logic ctl_pin, fb_pin, tx_out, pwm, dir, f_o, f_oe, a_o, a_oe, e_led, s_led;
  logic [15:0] eflags;
  int n_errors = 0, num_checks = 0, n;
  always #10 clk = ~clk;
  motor_side_model i_motor_side_model (.clk_in(clk), .fb_level_in(fb_level),
    .cmd_level_in(cmd_level), .pwm_in(pwm), .input_adc_out(in_adc),
    .feedback_adc_out(fb_adc), .current_adc_out(cur_adc),
    .control_out(ctl_pin), .feedback_pin_out(fb_pin));
  pid_motor_loop #(.MS_CYCLES(MS), .SLOW_HALF(SLOW), .FAST_HALF(FAST))
  i_pid_motor_loop (.CLK_IN(clk), .ARST_N_IN(arst_n), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .INPUT_ADC_IN(in_adc), .FEEDBACK_ADC_IN(fb_adc),
    .CURRENT_ADC_IN(cur_adc), .CONTROL_IN(ctl_pin), .feedback_in(fb_pin),
    .SERIAL_TX_DATA_IN(tx_bit), .SERIAL_TX_OUT(tx_out),
    .ERROR_FLAGS_OUT(eflags), .PWM_OUT(pwm), .DIR_OUT(dir), .FAULT_OUT(f_o),
    .FAULT_OE_OUT(f_oe), .AUX_OUT(a_o), .AUX_OE_OUT(a_oe),
    .ERR_LED_OUT(e_led), .STATUS_LED_OUT(s_led));
  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Cycles until lvl is seen; bound exhausted ends the run
  task automatic wait_aux(input logic lvl, input int lim, output int c);
    c = 0;
    while (a_o !== lvl) begin
      @(negedge clk);
      c++;
      if (c > lim) begin n_errors++; report_and_stop(); end
    end
  endtask
  task automatic led_gap(output int c);
    logic v;
    c = 0;
    v = s_led;
    while (s_led === v) begin
      @(negedge clk);
      c++;
      if (c > 2000) begin n_errors++; report_and_stop(); end
    end
  endtask
  // One blink half period: the second gap is a whole one
  task automatic blink(output int c);
    led_gap(c);
    led_gap(c);
  endtask
  task automatic high_count(input logic s, input int len, output int c);
    c = 0;
    repeat (len) begin
      @(negedge clk);
      if (s === 1'b1 && len == 600) c += (pwm === 1'b1);
      else c += (s_led === 1'b1);
    end
  endtask
  task automatic settle;
    repeat (3000) @(posedge clk);
  endtask
  // ---------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    `CHK({a_oe, a_o, f_oe, e_led}, 4'b1100)
    rd_reg(`ADDR_CTRL, d); `CHK(d, `CTRL_RESET)
    rd_reg(`ADDR_PERIOD, d); `CHK(d, {24'h0, `PERIOD_RESET})
    rd_reg(`ADDR_LIMITS, d); `CHK(d, `LIMITS_RESET)
    rd_reg(8'h3c, d); `CHK(d, 32'h0)
    wr_reg(`ADDR_PERIOD, 32'h0);
    rd_reg(`ADDR_PERIOD, d); `CHK(d, 32'h1)
    wr_reg(`ADDR_ERRORS, 32'h1);
    repeat (4) @(negedge clk);
    `CHK({e_led, f_oe, f_o, eflags}, {3'b111, 16'h0001})
    high_count(1'b0, 200, n); `CHK(n, 0)
    wr_reg(`ADDR_ERRORS, 32'h0);
    repeat (4) @(negedge clk);
    `CHK({e_led, f_oe}, 2'b00)
    blink(n); `CHK(n, SLOW)
    // Speed mode: fast ramp, full duty limit
    wr_reg(`ADDR_LIMITS, 32'h0009_6258);
    wr_reg(`ADDR_CTRL, 32'h1);
    settle();
    blink(n); `CHK(n, SLOW)
    cmd_level <= 12'd2348;
    settle();
    high_count(1'b1, 600, n); `CHK({n, dir}, {32'd300, 1'b0})
    high_count(1'b0, 200, n); `CHK(n, 200)
    cmd_level <= 12'd1748;
    settle();
    high_count(1'b1, 600, n); `CHK({n, dir}, {32'd300, 1'b1})
    wr_reg(`ADDR_LIMITS, 32'h0009_60c8);
    settle();
    high_count(1'b1, 600, n); `CHK(n, 200)
    wr_reg(`ADDR_CTRL, 32'h0);
    settle();
    high_count(1'b1, 600, n); `CHK(n, 0)
    // Tach feedback and pulse input, motor still off
    wr_reg(`ADDR_CTRL, 32'h60);
    repeat (300) @(posedge clk);
    rd_reg(`ADDR_MEAS, d);
    `CHK(d[23:12] >= 12'd11 && d[23:12] <= 12'd13, 1'b1)
    `CHK(d[11:0] <= 12'd2, 1'b1)
    // Position mode: far from target, then inside the band
    cmd_level <= 12'd3000;
    fb_level <= 12'd1000;
    wr_reg(`ADDR_CTRL, 32'h3);
    settle();
    blink(n); `CHK(n, FAST)
    // Unit P gain: error -2000 saturates duty target, max duty 200 caps duty
    wr_reg(`ADDR_GAIN_P, 32'h1);
    settle();
    rd_reg(`ADDR_DUTY, d); `CHK(d, 32'hfda8_ff38)
    fb_level <= 12'd2990;
    settle();
    high_count(1'b0, 200, n); `CHK(n, 200)
    // Disconnect probe on a 100 ms period
    wr_reg(`ADDR_PERIOD, 32'd100);
    wr_reg(`ADDR_CTRL, 32'h4);
    wait_aux(1'b0, 12000, n);
    wait_aux(1'b1, 8000, n); `CHK(n, `PROBE_CYCLES)
    wait_aux(1'b0, 12000, n); `CHK(n, MS * 100 - `PROBE_CYCLES)
    wr_reg(`ADDR_CTRL, 32'h10);
    repeat (3) @(negedge clk);
    `CHK(a_oe, 1'b0)
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      tx_bit <= i[0] ^ i[2];
      repeat (4) @(posedge clk);
      @(negedge clk);
      `CHK(tx_out, tx_bit)
    end
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd_reg(`ADDR_CTRL, d); `CHK(d, `CTRL_RESET)
    report_and_stop();
  end
endmodule // pid_motor_loop_tb
